//--- design/pbsp_burst_counter.sv
// Two-bit burst counter with linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module pbsp_burst_counter #(
   parameter int BW = pbsp_pkg::BURST_W
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          qual,
   input  wire logic          load,
   input  wire logic          advance,
   input  wire logic          interleaved,
   input  wire logic [BW-1:0] start,
   output logic      [BW-1:0] offset
);
   if (BW != 2)
   begin : g_bad_width
      $error("burst counter serves two bits only");
   end

   logic [BW-1:0] start_q;
   logic [BW-1:0] count_q;
   logic [BW-1:0] count_d;
   logic [BW-1:0] start_d;
   wire  [BW-1:0] count_inc = count_q + pbsp_pkg::BURST_STEP;

   // Count wraps inside two bits; upper address untouched
   assign count_d = load ? '0 : (advance ? count_inc : count_q);
   assign start_d = load ? start : start_q;
   // Offset of the coming edge, so the first advance already steps
   // Linear adds the count, interleaved xors it
   assign offset = interleaved ? (start_d ^ count_d)
                               : (start_d + count_d);

   // Frozen whenever the clock qualifier is high
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         start_q <= '0;
         count_q <= '0;
      end
      else if (qual)
      begin
         start_q <= start_d;
         count_q <= count_d;
      end
   end
endmodule
`default_nettype wire

//--- design/pbsp_pkg.sv
// Package with constants for the pipelined burst SRAM port
package pbsp_pkg;
   localparam int ADDR_W      = 17;          // 128 K locations
   localparam int LANES       = 4;
   localparam int LANE_W      = 9;           // Byte plus parity bit
   localparam int DATA_W      = LANES * LANE_W;
   localparam int BURST_W     = 2;
   localparam int READ_LAT    = 2;           // Qualified edges, address to data
   localparam int PIN_SYNC    = 3;           // Stages on the async output enable
   localparam logic [1:0] BURST_STEP = 2'h1;
endpackage

//--- design/pbsp_port.sv
// Control port and storage of a pipelined burst SRAM
//
// Summary of operation
// - Address picks one of 128 K locations
// - Address captured on rising clock edge
// - Low two address bits seed burst counter
// - Lane written when its strobe and write-enable low
// - Write enable sampled only on qualified edges
// - Advance high steps the burst counter while selected
// - Advance low loads a fresh address
// - Edges with qualifier high are ignored, except by the output enable sync
// - Selected only by low, high, low enables
// - Output enable low only permits driving
// - Output enable high floats data pins
// - Outputs float during write data phase
// - Outputs float first cycle after deselect
// - Outputs float while deselected
// - Qualifier high freezes state except output enable sync, keeps selection
// - Strap low linear, high interleaved order
`timescale 1ns/1ps
`default_nettype none
module pbsp_port #(
   parameter int AW = pbsp_pkg::ADDR_W,
   parameter int NL = pbsp_pkg::LANES,
   parameter int LW = pbsp_pkg::LANE_W
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [AW-1:0]    address,
   input  wire logic [NL-1:0]    byte_lane_write_n,
   input  wire logic             write_enable_n,
   input  wire logic             advance_or_load,
   input  wire logic             clock_qualifier_n,
   input  wire logic             chip_select_first_n,
   input  wire logic             chip_select_second,
   input  wire logic             chip_select_third_n,
   input  wire logic             output_enable_n,
   input  wire logic             burst_order_strap,
   input  wire logic [NL*LW-1:0] dq_in,
   output logic      [NL*LW-1:0] dq_out,
   output logic                  dq_oe_n
);
   localparam int DW = NL * LW;
   localparam int DEPTH = 1 << AW;
   localparam int BW = pbsp_pkg::BURST_W;
   localparam int PIN_STAGES = pbsp_pkg::PIN_SYNC;

   // Two register stages fix the latency; other values are not served
   if (AW <= BW || NL < 1 || LW < 1 || PIN_STAGES < 2 || pbsp_pkg::READ_LAT != 2)
   begin : g_bad_geometry
      $error("bad port geometry");
   end

   // Storage array, one word per location
   logic [DW-1:0] mem [DEPTH];

   // Pipeline stage 1: captured command
   logic          sel_q;
   logic          wr_q;
   logic [NL-1:0] lanes_q;
   logic [AW-1:0] addr_q;
   // Pipeline stage 2: data phase
   logic          sel2_q;
   logic          wr2_q;
   logic [NL-1:0] lanes2_q;
   logic [AW-1:0] addr2_q;
   logic          was_desel_q;
   logic          emerge_q;
   logic [DW-1:0] rdata_q;
   logic          rvalid_q;
   logic [PIN_STAGES-1:0] oe_sync_q;
   logic          oe_allow_q;

   // Qualified edge and decoded command
   wire qual     = ~clock_qualifier_n;
   wire selected = ~chip_select_first_n & chip_select_second
                   & ~chip_select_third_n;
   wire loading  = ~advance_or_load;
   wire advance  = advance_or_load & sel_q;
   wire wr_now   = loading ? ~write_enable_n : wr_q;
   wire sel_now  = loading ? selected : sel_q;

   // Burst offset from counter, upper bits from captured address
   logic [BW-1:0] offset;
   pbsp_burst_counter #(
      .BW (BW)
   ) u_burst (
      .clock       (clock),
      .rst         (rst),
      .qual        (qual),
      .load        (loading),
      .advance     (advance),
      .interleaved (burst_order_strap),
      .start       (address[BW-1:0]),
      .offset      (offset)
   );

   wire [AW-1:0] base     = loading ? address : addr_q;
   wire [AW-1:0] cur_addr = loading ? address
                          : {addr_q[AW-1:BW], offset};

   // Command capture, only on qualified edges
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sel_q   <= 1'b0;
         wr_q    <= 1'b0;
         lanes_q <= '0;
         addr_q  <= '0;
      end
      else if (qual)
      begin
         sel_q   <= sel_now;
         wr_q    <= wr_now;
         lanes_q <= ~byte_lane_write_n;
         addr_q  <= loading ? base : cur_addr;
      end
   end

   // Data phase stage and deselect tracking
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sel2_q      <= 1'b0;
         wr2_q       <= 1'b0;
         lanes2_q    <= '0;
         addr2_q     <= '0;
         was_desel_q <= 1'b1;
         emerge_q    <= 1'b0;
      end
      else if (qual)
      begin
         sel2_q      <= sel_q;
         wr2_q       <= wr_q & sel_q;
         lanes2_q    <= lanes_q;
         addr2_q     <= addr_q;
         was_desel_q <= ~sel_q;
         emerge_q    <= was_desel_q & sel_q;
      end
   end

   // Merged word: strobed lanes take new data, others keep the old
   wire [DW-1:0] wmerge;
   genvar g;
   generate
      for (g = 0; g < NL; g++)
      begin : g_lane
         assign wmerge[g*LW +: LW] = lanes2_q[g] ? dq_in[g*LW +: LW]
                                                 : mem[addr2_q][g*LW +: LW];
      end
   endgenerate

   // Self-timed write; one process owns the array
   always_ff @(posedge clock)
   begin
      if (qual && wr2_q)
         mem[addr2_q] <= wmerge;
   end

   // Read data through output register
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end
      else if (qual)
      begin
         rdata_q  <= mem[addr_q];
         rvalid_q <= sel_q & ~wr_q;
      end
   end

   // Async output enable passes three flops; change taken when last two agree
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         oe_sync_q  <= '1;
         oe_allow_q <= 1'b0;
      end
      else
      begin
         oe_sync_q <= {oe_sync_q[PIN_STAGES-2:0], output_enable_n};
         if (oe_sync_q[PIN_STAGES-1] == oe_sync_q[PIN_STAGES-2])
            oe_allow_q <= ~oe_sync_q[PIN_STAGES-1];
      end
   end

   // Drivers masked on write data, emerging cycle and deselect
   wire drive = oe_allow_q & rvalid_q & sel2_q & ~wr2_q & ~emerge_q;
   assign dq_oe_n = ~drive;
   assign dq_out  = rdata_q;

   // Deselected command floats its data cycle
   desel_float_a: assert property (@(posedge clock) disable iff (rst)
      qual && !sel_q |=> dq_oe_n)
      else $error("data driven while deselected");
   // Write data phase keeps pins floating
   write_float_a: assert property (@(posedge clock) disable iff (rst)
      qual && sel_q && wr_q |=> dq_oe_n)
      else $error("data driven during write phase");
   // Settled output enable high must float pins
   oe_float_a: assert property (@(posedge clock) disable iff (rst)
      oe_sync_q[PIN_STAGES-1] && oe_sync_q[PIN_STAGES-2] |=> dq_oe_n)
      else $error("data driven with output enable high");
   // Emerging cycle floats
   emerge_float_a: assert property (@(posedge clock) disable iff (rst)
      emerge_q |-> dq_oe_n)
      else $error("data driven when leaving deselect");
   // Qualifier high freezes command state
   freeze_cmd_a: assert property (@(posedge clock) disable iff (rst)
      clock_qualifier_n |=> $stable(sel_q) && $stable(addr_q) && $stable(wr_q))
      else $error("state moved on unqualified edge");
   // Selection follows the enable decode on a load
   select_dec_a: assert property (@(posedge clock) disable iff (rst)
      qual && loading |=> sel_q == $past(selected))
      else $error("selection decode wrong");
   // Load captures the full address
   load_addr_a: assert property (@(posedge clock) disable iff (rst)
      qual && loading |=> addr_q == $past(address))
      else $error("address not loaded");
   // Advance keeps upper address bits
   burst_upper_a: assert property (@(posedge clock) disable iff (rst)
      qual && !loading |=> addr_q[AW-1:BW] == $past(addr_q[AW-1:BW]))
      else $error("burst changed upper bits");
   // Linear advance steps to the next location at once
   burst_step_a: assert property (@(posedge clock) disable iff (rst)
      qual && !loading && sel_q && !burst_order_strap
      |=> addr_q[BW-1:0] == BW'($past(addr_q[BW-1:0]) + 1'b1))
      else $error("advance did not step the burst");
   // Write flag taken from write enable on load
   write_cap_a: assert property (@(posedge clock) disable iff (rst)
      qual && loading |=> wr_q == !$past(write_enable_n))
      else $error("write enable not sampled");
endmodule
`default_nettype wire

//--- verification/pbsp_ctrl_model.sv
// Memory controller model: advance gating and write data lines
`timescale 1ns/1ps
`default_nettype none
module pbsp_ctrl_model (
   input  wire logic        clock,
   input  wire logic        c_qn,
   input  wire logic [2:0]  c_cs,
   input  wire logic        c_adv,
   input  wire logic        c_dv,
   input  wire logic [35:0] c_din,
   output logic             adv,
   output logic      [35:0] din
);
   logic        desel_q = 1'b1;
   logic [35:0] last_q  = 36'h0;
   // A burst may not be continued straight after a deselect
   assign adv = c_adv & ~desel_q;
   // Released lines show the inverse, never a stale match
   assign din = c_dv ? c_din : ~last_q;
   // Frozen edges leave the state alone
   always @(posedge clock)
      if (!c_qn)
      begin
         desel_q <= c_cs != 3'h2;
         last_q  <= din;
      end
endmodule
`default_nettype wire

//--- verification/pbsp_port_tb.sv
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module pbsp_port_tb;
   localparam logic [2:0]  SEL = 3'h2;
   localparam logic [16:0] B   = 17'h00100;
   logic        clock, rst, we_n, adv_c, adv, qn, oe_n, strap, dv, dq_oe_n;
   logic        q_nx, oe_nx, st_nx;
   logic [2:0]  cs;
   logic [3:0]  bw, bw_nx;
   logic [16:0] addr;
   logic [35:0] din_c, din, dq_out;
   logic [35:0] exp_m [int];
   int          num_errors, compares;
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   pbsp_ctrl_model u_pbsp_ctrl_model (.clock(clock), .c_qn(qn), .c_cs(cs), .c_adv(adv_c),
      .c_dv(dv), .c_din(din_c), .adv(adv), .din(din));
   pbsp_port u_pbsp_port (.clock(clock), .rst(rst), .address(addr), .byte_lane_write_n(bw),
      .write_enable_n(we_n), .advance_or_load(adv), .clock_qualifier_n(qn),
      .chip_select_first_n(cs[2]), .chip_select_second(cs[1]), .chip_select_third_n(cs[0]),
      .output_enable_n(oe_n), .burst_order_strap(strap), .dq_in(din), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n));
   function automatic logic [35:0] d_of(input logic [16:0] a);
      return {a[8:0] ^ 9'h155, a[8:0] ^ 9'h0AA, a[8:0], ~a[8:0]};
   endfunction
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // One controller cycle, changed at the falling edge
   task automatic cyc(input logic [2:0] s, input logic v, input logic w, input logic [16:0] a,
                      input logic [35:0] d, input logic dvl);
      @(negedge clock);
      cs = s;
      adv_c = v;
      we_n = w;
      addr = a;
      din_c = d;
      dv = dvl;
      qn = q_nx;
      oe_n = oe_nx;
      strap = st_nx;
      bw = bw_nx;
      @(posedge clock);
      #1;
   endtask
   // Load, three advances, two fillers; data stands after the edge past capture
   task automatic run_rd(input logic [16:0] a, input logic il);
      logic [1:0] o;
      for (int k = 1; k < 7; k++)
      begin
         cyc(SEL, k > 1 && k < 5, 1'b1, (k > 1 && k < 5) ? 17'h0 : a, 36'h0, 1'b0);
         o = il ? a[1:0] ^ 2'(k - 2) : a[1:0] + 2'(k - 2);
         if (k > 1)
            chk(dq_oe_n === 1'b0 && dq_out === exp_m[{a[16:2], o}],
                "burst read");
      end
   endtask
   task automatic t_write;
      // Write data follows its command by two edges
      for (int i = 0; i < 10; i++)
      begin
         cyc(SEL, i > 4 && i < 8, i > 7, (i > 4 && i < 8) ? 17'h0 : B + 17'(i),
             d_of(B + 17'(i) - 17'h2), i > 1);
         if (i < 8)
            exp_m[B + 17'(i)] = d_of(B + 17'(i));
         if (i > 0 && i < 9)
            chk(dq_oe_n === 1'b1, "drove in write data");
      end
      bw_nx = 4'hD;
      cyc(SEL, 1'b0, 1'b0, B + 17'h1, 36'h0, 1'b0);
      bw_nx = 4'h0;
      cyc(SEL, 1'b0, 1'b1, B, 36'h0, 1'b0);
      cyc(SEL, 1'b0, 1'b1, B, 36'hFFFFFFFFF, 1'b1);
      exp_m[B + 17'h1][17:9] = 9'h1FF;
      run_rd(B, 1'b0);
      run_rd(B + 17'h4, 1'b0);
      $display("write test done");
   endtask
   task automatic t_order;
      st_nx = 1'b1;
      cyc(SEL, 1'b0, 1'b1, B, 36'h0, 1'b0);
      run_rd(B + 17'h1, 1'b1);
      run_rd(B + 17'h6, 1'b1);
      st_nx = 1'b0;
      run_rd(B + 17'h5, 1'b0);
      $display("order test done");
   endtask
   // Frozen edges carry a deselect and a write that must not land
   task automatic t_freeze;
      cyc(SEL, 1'b0, 1'b1, B + 17'h2, 36'h0, 1'b0);
      q_nx = 1'b1;
      repeat (3) cyc(3'h7, 1'b0, 1'b0, 17'h0, 36'h0, 1'b1);
      q_nx = 1'b0;
      cyc(SEL, 1'b1, 1'b1, 17'h0, 36'h0, 1'b0);
      chk(dq_oe_n === 1'b0 && dq_out === exp_m[B + 17'h2], "frozen read");
      cyc(SEL, 1'b1, 1'b1, 17'h0, 36'h0, 1'b0);
      chk(dq_out === exp_m[B + 17'h3], "burst after freeze");
      $display("freeze test done");
   endtask
   task automatic t_desel;
      int i;
      i = 0;
      for (int c = 0; c < 8; c++)
         if (c != 2)
         begin
            cyc(3'(c), 1'b1, 1'b1, B, 36'h0, 1'b0);
            if (i++ > 1)
               chk(dq_oe_n === 1'b1, "drove while deselected");
         end
      cyc(SEL, 1'b1, 1'b1, B, 36'h0, 1'b0);
      cyc(SEL, 1'b0, 1'b1, B + 17'h1, 36'h0, 1'b0);
      chk(dq_oe_n === 1'b1, "drove on emerging cycle");
      cyc(SEL, 1'b0, 1'b1, B + 17'h1, 36'h0, 1'b0);
      chk(dq_oe_n === 1'b0 && dq_out === exp_m[B + 17'h1], "read after emerge");
      oe_nx = 1'b1;
      repeat (5) cyc(SEL, 1'b0, 1'b1, B, 36'h0, 1'b0);
      chk(dq_oe_n === 1'b1, "drove with enable high");
      oe_nx = 1'b0;
      repeat (5) cyc(SEL, 1'b0, 1'b1, B, 36'h0, 1'b0);
      chk(dq_oe_n === 1'b0 && dq_out === exp_m[B], "enable low read");
      $display("select test done");
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Reset for two cycles, then the scenarios in turn
   initial
   begin
      {cs, adv_c, we_n, addr, din_c, dv} = {3'h7, 1'b0, 1'b1, 17'h0, 36'h0, 1'b0};
      {qn, oe_n, strap, bw, q_nx, oe_nx, st_nx, bw_nx} = 14'h0;
      rst = 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      chk(dq_oe_n === 1'b1, "output enabled after reset");
      t_write;
      t_order;
      t_freeze;
      t_desel;
      report_and_stop;
   end
endmodule
`default_nettype wire
